// >>> mcs_defines.svh
// Constants of the motion cycle supervisor: offsets, fields, reset values and timing.
// Contract
// - Cycle is chosen from 0.2 to 14.2 ms or default; one command tick per cycle.
// - Default choice follows axis count and operating-system variant, slightly longer actual cycles.
// - Computation longer than the cycle sets the overrun flag, also under default choice.
// - Measured computation time and current cycle setting are published in microseconds.
// - Switch mode: stop-to-run sets controller ready, run-to-stop clears it.
// - Switch mode: power-up with switch at run also sets controller ready.
// - Gated mode: at run, a rise of request word bit 0 or request bit sets ready.
// - Gated mode: a fall of either request, or run-to-stop, clears ready.
// - Forced-stop source is a selectable pin or internal bit, active low.
// - While forced stop is asserted every servo axis is stopped at once.
// - The hardware emergency stop terminal always forces a stop, whatever the settings.
// - An option decides whether warnings update error flag, servo codes, history and diagnostics; amplifier codes always update.
// - Each history entry holds twelve words: program, type, axis, code, time, setting data; the setting-data words are written as zero.
// - Axis index runs 0 to 31 for axes 1 to 32.
// - History index runs 0 to 7, eight entries.
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH

`define MCS_CLK_PERIOD_NS 10
`define MCS_US_NS         1000
`define MCS_CYC_PER_US    (`MCS_US_NS / `MCS_CLK_PERIOD_NS)

`define MCS_OFF_CTRL      12'h000
`define MCS_OFF_READY_REQ 12'h004
`define MCS_OFF_STATUS    12'h008
`define MCS_OFF_MEAS      12'h00c
`define MCS_OFF_SETTING   12'h010
`define MCS_OFF_DIAG_CODE 12'h014
`define MCS_OFF_ERR_CAT   12'h018
`define MCS_OFF_ERR_INFO  12'h01c
`define MCS_RGN_REGS      4'h0
`define MCS_RGN_SERVO     4'h1
`define MCS_RGN_AMP       4'h2
`define MCS_RGN_HIST      3'h2

`define MCS_CTRL_SEL_LSB   0
`define MCS_CTRL_OS_LSB    4
`define MCS_CTRL_MODE_BIT  6
`define MCS_CTRL_REPORT    7
`define MCS_CTRL_SRC_BIT   8
`define MCS_CTRL_STOP_BIT  9
`define MCS_CTRL_REQ_BIT   10
`define MCS_CTRL_AXES_LSB  16
`define MCS_CTRL_RESET     32'h0001_0180
`define MCS_CTRL_WMASK     32'h003f_07ff

`define MCS_ST_READY    0
`define MCS_ST_OVERRUN  1
`define MCS_ST_MERR     2
`define MCS_ST_DIAG     3
`define MCS_ST_SDIAG    4
`define MCS_ST_FSTOP    5

`define MCS_US_0P2  16'h00de
`define MCS_US_0P4  16'h01bc
`define MCS_US_0P8  16'h0378
`define MCS_US_1P7  16'h06f1
`define MCS_US_3P5  16'h0de3
`define MCS_US_7P1  16'h1bbc
`define MCS_US_14P2 16'h3778

`define MCS_HIST_WORDS   4'hc
`define MCS_HIST_LAST    4'hb
`define MCS_HIST_DEPTH   96
`define MCS_AXES         32
`define MCS_WARN_TYPE    16'h0001
`define MCS_WARN_CAT     16'h0002

`endif

// >>> mcs_pkg.sv
// Types shared by the motion cycle supervisor modules.
package mcs_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {OS_A = 2'h0, OS_B = 2'h1, OS_C = 2'h2} os_variant_t;
  typedef enum logic {READY_SWITCH = 1'b0, READY_GATED = 1'b1} ready_mode_t;
  typedef enum logic {HIST_IDLE = 1'b0, HIST_FILL = 1'b1} hist_state_t;
endpackage

// >>> word_mem.sv
// Small word memory with one write port and a registered read port.
`timescale 1ns/1ps
`include "mcs_defines.svh"
module word_mem
  import mcs_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW    = 5
)(
  input  wire logic          clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire word_t         wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output word_t              rd_data_o
);
  word_t mem_q [DEPTH];

  // Contents are not reset; software reads undefined words until the first event fills them.
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= (32'(rd_addr_i) < DEPTH) ? mem_q[rd_addr_i] : 16'h0000;
  end
endmodule

// >>> cycle_timer.sv
// Operation cycle tick generator, computation time meter and overrun detector.
`timescale 1ns/1ps
`include "mcs_defines.svh"
module cycle_timer
  import mcs_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  sys_rst_i,
  input  wire word_t cycle_us_i,
  input  wire logic  compute_busy_i,
  output logic       cycle_tick_o,
  output word_t      measured_us_o,
  output logic       overrun_o
);
  localparam logic [6:0] PRE_LAST = 7'(`MCS_CYC_PER_US - 1);

  logic [6:0] pre_q;
  word_t      us_q;
  logic       busy_q;
  logic       us_end;
  logic       tick_w;
  logic       busy_fall;

  // A shortened setting takes effect at once, since the compare is greater-or-equal.
  assign us_end    = (pre_q == PRE_LAST);
  assign tick_w    = us_end && ((us_q + 16'h0001) >= cycle_us_i);
  assign busy_fall = busy_q && !compute_busy_i;

  // Microsecond counter restarted at every cycle tick.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pre_q  <= 7'h00;
      us_q   <= 16'h0000;
      busy_q <= 1'b0;
    end
    else
    begin
      pre_q  <= us_end ? 7'h00 : pre_q + 7'h01;
      us_q   <= tick_w ? 16'h0000 : (us_end ? us_q + 16'h0001 : us_q);
      busy_q <= compute_busy_i;
    end
  end

  // Computation still running at the tick means it outran the cycle.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cycle_tick_o  <= 1'b0;
      overrun_o     <= 1'b0;
      measured_us_o <= 16'h0000;
    end
    else
    begin
      cycle_tick_o <= tick_w;
      overrun_o    <= tick_w && compute_busy_i;
      if (tick_w && compute_busy_i)
      begin
        measured_us_o <= cycle_us_i;
      end
      else if (busy_fall)
      begin
        measured_us_o <= us_q;
      end
    end
  end
endmodule

// >>> motion_cycle_supervisor.sv
// Motion cycle supervisor top: AHB-Lite registers, ready flag, forced stop and warnings.
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "mcs_defines.svh"
module motion_cycle_supervisor
  import mcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        run_stop_i,
  input  wire logic        real_input_device_i,
  input  wire logic        hardware_emergency_stop_terminal_n_i,
  input  wire logic        compute_busy_i,
  input  wire logic        servo_warn_i,
  input  wire logic [4:0]  warn_axis_i,
  input  wire word_t       warn_code_i,
  input  wire word_t       program_no_i,
  input  wire word_t       time_ym_i,
  input  wire word_t       time_dh_i,
  input  wire word_t       time_ms_i,
  output logic             cycle_tick_o,
  output logic             servo_stop_o,
  output logic             controller_ready_flag_o,
  output logic             cycle_overrun_flag_o,
  output logic             motion_error_flag_o
);
  // Cycle in microseconds from the fixed menu or, for selection 0, from the axis table.
  function automatic word_t cycle_us_f(input logic [3:0] sel, input os_variant_t os,
                                       input logic [5:0] axes);
    word_t r;
    r = `MCS_US_0P2;
    case (sel)
      4'h1: r = `MCS_US_0P2;
      4'h2: r = `MCS_US_0P4;
      4'h3: r = `MCS_US_0P8;
      4'h4: r = `MCS_US_1P7;
      4'h5: r = `MCS_US_3P5;
      4'h6: r = `MCS_US_7P1;
      4'h7: r = `MCS_US_14P2;
      4'h0:
      begin
        case (os)
          OS_A: r = (axes <= 6'h04) ? `MCS_US_0P2 : (axes <= 6'h0a) ? `MCS_US_0P4 :
                    (axes <= 6'h18) ? `MCS_US_0P8 : `MCS_US_1P7;
          OS_B: r = (axes <= 6'h06) ? `MCS_US_0P4 : (axes <= 6'h10) ? `MCS_US_0P8 :
                    `MCS_US_1P7;
          default: r = (axes <= 6'h04) ? `MCS_US_0P4 : (axes <= 6'h0c) ? `MCS_US_0P8 :
                       (axes <= 6'h1c) ? `MCS_US_1P7 : `MCS_US_3P5;
        endcase
      end
      default: r = `MCS_US_14P2;
    endcase
    return r;
  endfunction

  logic [31:0] ctrl_q;
  word_t       ready_req_word_q;
  logic        ready_q, overrun_q, merr_q, diag_q, sdiag_q, fstop_q;
  word_t       setting_q, diag_code_q, err_cat_q, err_info_q;
  logic        dph_q, dwr_q;
  logic [11:0] daddr_q;
  logic        run_meta_q, run_q, run_prev_q;
  logic        pin_meta_q, pin_q, estop_meta_q, estop_n_q;
  logic        req_prev_q, bit_prev_q;
  hist_state_t hist_state_q;
  logic [3:0]  hist_word_q;
  logic [2:0]  hist_entry_q;
  logic [4:0]  lat_axis_q;
  word_t       lat_code_q, lat_prog_q, lat_ym_q, lat_dh_q, lat_ms_q;
  word_t       measured_us, servo_rd, amp_rd, hist_rd, hist_wdata;
  logic        overrun_set;
  logic [31:0] reg_rd;

  // Bus decode; the slave never stalls and always answers OKAY.
  logic addr_ok, wr_stb, st_wr, report_en, warn_rep, run_rise, run_fall;
  logic req_rise, req_fall, bit_rise, bit_fall, gated, rdy_set, rdy_clr, stop_src;
  logic [6:0] hist_widx;
  assign addr_ok     = hsel_i && htrans_i[1] && hready_i;
  assign wr_stb      = dph_q && dwr_q;
  assign st_wr       = wr_stb && (daddr_q == `MCS_OFF_STATUS);
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Address phase is captured here; the write lands in the data phase.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      dph_q   <= 1'b0;
      dwr_q   <= 1'b0;
      daddr_q <= 12'h000;
    end
    else
    begin
      dph_q   <= addr_ok;
      dwr_q   <= addr_ok && hwrite_i;
      daddr_q <= addr_ok ? haddr_i[11:0] : daddr_q;
    end
  end

  // Software-written control and request registers.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q           <= `MCS_CTRL_RESET;
      ready_req_word_q <= 16'h0000;
    end
    else if (wr_stb && daddr_q == `MCS_OFF_CTRL)
    begin
      ctrl_q <= hwdata_i & `MCS_CTRL_WMASK;
    end
    else if (wr_stb && daddr_q == `MCS_OFF_READY_REQ)
    begin
      ready_req_word_q <= hwdata_i[15:0];
    end
  end

  // Pins pass two flops; reset to stop, so power-up at run looks like a stop-to-run move.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      {run_meta_q, run_q, run_prev_q} <= 3'h0;
      {pin_meta_q, pin_q}             <= 2'h0;
      {estop_meta_q, estop_n_q}       <= 2'h0;
      {req_prev_q, bit_prev_q}        <= 2'h0;
    end
    else
    begin
      {run_meta_q, run_q, run_prev_q} <= {run_stop_i, run_meta_q, run_q};
      {pin_meta_q, pin_q}             <= {real_input_device_i, pin_meta_q};
      {estop_meta_q, estop_n_q}       <= {hardware_emergency_stop_terminal_n_i, estop_meta_q};
      req_prev_q                      <= ready_req_word_q[0];
      bit_prev_q                      <= ctrl_q[`MCS_CTRL_REQ_BIT];
    end
  end

  // Ready flag: the switch alone, or the switch gated by software request edges.
  assign run_rise = run_q && !run_prev_q;
  assign run_fall = !run_q && run_prev_q;
  assign req_rise = ready_req_word_q[0] && !req_prev_q;
  assign req_fall = !ready_req_word_q[0] && req_prev_q;
  assign bit_rise = ctrl_q[`MCS_CTRL_REQ_BIT] && !bit_prev_q;
  assign bit_fall = !ctrl_q[`MCS_CTRL_REQ_BIT] && bit_prev_q;
  assign gated    = (ready_mode_t'(ctrl_q[`MCS_CTRL_MODE_BIT]) == READY_GATED);
  assign rdy_set  = gated ? (run_q && (req_rise || bit_rise)) : run_rise;
  assign rdy_clr  = run_fall || (gated && (req_fall || bit_fall));

  // Forced stop is active low on the chosen source; the terminal cannot be masked.
  assign stop_src = ctrl_q[`MCS_CTRL_SRC_BIT] ? ctrl_q[`MCS_CTRL_STOP_BIT] : pin_q;
  assign report_en = ctrl_q[`MCS_CTRL_REPORT];
  assign warn_rep  = servo_warn_i && report_en;

  // Status flags; a hardware set in the cycle of a software clear wins.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ready_q   <= 1'b0;
      fstop_q   <= 1'b1;
      overrun_q <= 1'b0;
      merr_q    <= 1'b0;
      diag_q    <= 1'b0;
      sdiag_q   <= 1'b0;
      setting_q <= `MCS_US_0P2;
    end
    else
    begin
      ready_q   <= rdy_set ? 1'b1 : (rdy_clr ? 1'b0 : ready_q);
      fstop_q   <= !stop_src || !estop_n_q;
      overrun_q <= overrun_set || (overrun_q && !(st_wr && hwdata_i[`MCS_ST_OVERRUN]));
      merr_q    <= warn_rep || (merr_q && !(st_wr && hwdata_i[`MCS_ST_MERR]));
      diag_q    <= warn_rep || (diag_q && !(st_wr && hwdata_i[`MCS_ST_DIAG]));
      sdiag_q   <= warn_rep || (sdiag_q && !(st_wr && hwdata_i[`MCS_ST_SDIAG]));
      setting_q <= cycle_us_f(ctrl_q[3:0], os_variant_t'(ctrl_q[5:4]), ctrl_q[21:16]);
    end
  end

  // Diagnostic words follow each reported warning.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      diag_code_q <= 16'h0000;
      err_cat_q   <= 16'h0000;
      err_info_q  <= 16'h0000;
    end
    else if (warn_rep)
    begin
      diag_code_q <= warn_code_i;
      err_cat_q   <= `MCS_WARN_CAT;
      err_info_q  <= {11'h000, warn_axis_i} + 16'h0001;
    end
  end

  // History writer: twelve words per entry, one per cycle; warnings while busy skip history.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      hist_state_q <= HIST_IDLE;
      hist_word_q  <= 4'h0;
      hist_entry_q <= 3'h0;
    end
    else
    begin
      case (hist_state_q)
        HIST_IDLE: hist_state_q <= warn_rep ? HIST_FILL : HIST_IDLE;
        HIST_FILL:
        begin
          hist_word_q <= (hist_word_q == `MCS_HIST_LAST) ? 4'h0 : hist_word_q + 4'h1;
          if (hist_word_q == `MCS_HIST_LAST)
          begin
            hist_state_q <= HIST_IDLE;
            hist_entry_q <= hist_entry_q + 3'h1;
          end
        end
        default: hist_state_q <= HIST_IDLE;
      endcase
    end
  end

  // Snapshot of the warning that the history writer is recording.
  always_ff @(posedge clk_i)
  begin
    if (warn_rep && hist_state_q == HIST_IDLE)
    begin
      {lat_axis_q, lat_code_q, lat_prog_q} <= {warn_axis_i, warn_code_i, program_no_i};
      {lat_ym_q, lat_dh_q, lat_ms_q}       <= {time_ym_i, time_dh_i, time_ms_i};
    end
  end

  // Entry layout: program, type, axis, code, three time words, then five words of zero.
  always_comb
  begin
    case (hist_word_q)
      4'h0:    hist_wdata = lat_prog_q;
      4'h1:    hist_wdata = `MCS_WARN_TYPE;
      4'h2:    hist_wdata = {11'h000, lat_axis_q} + 16'h0001;
      4'h3:    hist_wdata = lat_code_q;
      4'h4:    hist_wdata = lat_ym_q;
      4'h5:    hist_wdata = lat_dh_q;
      4'h6:    hist_wdata = lat_ms_q;
      default: hist_wdata = 16'h0000;
    endcase
  end
  assign hist_widx = 7'(hist_entry_q * `MCS_HIST_WORDS) + 7'(hist_word_q);

  // Per-axis code memories and the history memory; reads start in the address phase.
  word_mem #(.DEPTH(`MCS_AXES), .AW(5)) u_servo_mem (
    .clk_i     (clk_i),
    .wr_en_i   (warn_rep),
    .wr_addr_i (warn_axis_i),
    .wr_data_i (warn_code_i),
    .rd_addr_i (haddr_i[6:2]),
    .rd_data_o (servo_rd)
  );
  word_mem #(.DEPTH(`MCS_AXES), .AW(5)) u_amp_mem (
    .clk_i     (clk_i),
    .wr_en_i   (servo_warn_i),
    .wr_addr_i (warn_axis_i),
    .wr_data_i (warn_code_i),
    .rd_addr_i (haddr_i[6:2]),
    .rd_data_o (amp_rd)
  );
  word_mem #(.DEPTH(`MCS_HIST_DEPTH), .AW(7)) u_hist_mem (
    .clk_i     (clk_i),
    .wr_en_i   (hist_state_q == HIST_FILL),
    .wr_addr_i (hist_widx),
    .wr_data_i (hist_wdata),
    .rd_addr_i (haddr_i[8:2]),
    .rd_data_o (hist_rd)
  );

  cycle_timer u_timer (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .cycle_us_i     (setting_q),
    .compute_busy_i (compute_busy_i),
    .cycle_tick_o   (cycle_tick_o),
    .measured_us_o  (measured_us),
    .overrun_o      (overrun_set)
  );

  // Register read mux for the data phase; unmapped words read as zero.
  always_comb
  begin
    case (daddr_q)
      `MCS_OFF_CTRL:      reg_rd = ctrl_q;
      `MCS_OFF_READY_REQ: reg_rd = {16'h0000, ready_req_word_q};
      `MCS_OFF_STATUS:    reg_rd = {26'h0, fstop_q, sdiag_q, diag_q, merr_q, overrun_q, ready_q};
      `MCS_OFF_MEAS:      reg_rd = {16'h0000, measured_us};
      `MCS_OFF_SETTING:   reg_rd = {16'h0000, setting_q};
      `MCS_OFF_DIAG_CODE: reg_rd = {16'h0000, diag_code_q};
      `MCS_OFF_ERR_CAT:   reg_rd = {16'h0000, err_cat_q};
      `MCS_OFF_ERR_INFO:  reg_rd = {16'h0000, err_info_q};
      default:            reg_rd = 32'h0000_0000;
    endcase
  end
  assign hrdata_o = !dph_q ? 32'h0000_0000 :
                    (daddr_q[11:8] == `MCS_RGN_REGS)  ? reg_rd :
                    (daddr_q[11:8] == `MCS_RGN_SERVO && !daddr_q[7]) ? {16'h0000, servo_rd} :
                    (daddr_q[11:8] == `MCS_RGN_AMP && !daddr_q[7])   ? {16'h0000, amp_rd} :
                    (daddr_q[11:9] == `MCS_RGN_HIST)  ? {16'h0000, hist_rd} : 32'h0000_0000;

  assign servo_stop_o            = fstop_q;
  assign controller_ready_flag_o = ready_q;
  assign cycle_overrun_flag_o    = overrun_q;
  assign motion_error_flag_o     = merr_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_run_rise;
    !gated && run_rise |=> ready_q;
  endproperty
  a_run_rise: assert property (p_run_rise) else $error("ready not set on run");
  property p_run_fall;
    run_fall |=> !ready_q;
  endproperty
  a_run_fall: assert property (p_run_fall) else $error("ready kept on stop");
  property p_gated_set;
    gated && run_q && req_rise |=> ready_q;
  endproperty
  a_gated_set: assert property (p_gated_set) else $error("request rise ignored");
  property p_gated_clr;
    gated && req_fall && !rdy_set |=> !ready_q;
  endproperty
  a_gated_clr: assert property (p_gated_clr) else $error("request fall ignored");
  property p_gated_no_sw;
    gated && run_rise && !req_rise && !bit_rise && !ready_q |=> !ready_q;
  endproperty
  a_gated_no_sw: assert property (p_gated_no_sw) else $error("gated ready by switch");
  property p_src_stop;
    ctrl_q[`MCS_CTRL_SRC_BIT] && !ctrl_q[`MCS_CTRL_STOP_BIT] |=> servo_stop_o;
  endproperty
  a_src_stop: assert property (p_src_stop) else $error("forced stop missed");
  property p_estop;
    !estop_n_q |=> servo_stop_o;
  endproperty
  a_estop: assert property (p_estop) else $error("terminal stop missed");
  property p_release;
    estop_n_q && stop_src |=> !servo_stop_o;
  endproperty
  a_release: assert property (p_release) else $error("stop not released");
  property p_overrun;
    compute_busy_i && u_timer.tick_w |=> ##1 overrun_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_no_report;
    servo_warn_i && !report_en && !merr_q |=> !merr_q;
  endproperty
  a_no_report: assert property (p_no_report) else $error("warning reported");
  property p_setting;
    $stable(ctrl_q) [*2] |-> setting_q == cycle_us_f(ctrl_q[3:0],
                              os_variant_t'(ctrl_q[5:4]), ctrl_q[21:16]);
  endproperty
  a_setting: assert property (p_setting) else $error("cycle setting wrong");
endmodule

// >>> servo_side_model.sv
// Far-side stand-in: motion computation load and servo amplifier warnings.
`timescale 1ns/1ps
module servo_side_model
  import mcs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cycle_tick_i,
  input  wire logic       slow_i,
  input  wire logic       warn_req_i,
  input  wire logic [4:0] axis_i,
  input  wire word_t      code_i,
  output logic            compute_busy_o,
  output logic            servo_warn_o,
  output logic [4:0]      warn_axis_o,
  output word_t           warn_code_o
);
  logic [7:0] busy_cnt_q;

  // Work starts at each tick; a slow partner never finishes, which forces an overrun.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_cnt_q <= 8'h00;
    else if (cycle_tick_i)
      busy_cnt_q <= 8'hc8;
    else if (busy_cnt_q != 8'h00)
      busy_cnt_q <= busy_cnt_q - 8'h01;
  end
  assign compute_busy_o = slow_i || (busy_cnt_q != 8'h00);

  // Warning fields are only valid with the pulse; otherwise they toggle so stale values never pass.
  always_ff @(posedge clk_i)
  begin
    servo_warn_o <= warn_req_i;
    warn_axis_o  <= warn_req_i ? axis_i : ~warn_axis_o;
    warn_code_o  <= warn_req_i ? code_i : ~warn_code_o;
  end
endmodule

// >>> testbench.sv
// Self-checking testbench of the motion cycle supervisor.
`timescale 1ns/1ps
`include "mcs_defines.svh"
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t read %h want %h", $time, act, exp); end end
module testbench
  import mcs_pkg::*;
;
  logic        clk_i, sys_rst_i, hwrite, hreadyout, hresp, tick, stop, ready, ovr, merr;
  logic        run, pin, estop_n, slow, wreq, busy, swarn;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd_smp, x;
  logic [4:0]  ax, wax;
  word_t       code, wcode, tw;
  int          n_fail, n_compared;
  time         t0;
  logic [4:0]  obs;

  assign obs = {tick, stop, merr, ovr, ready};

  // The clock and the register sample taken with the pre-edge value at each rising edge.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) rd_smp <= hrdata;

  motion_cycle_supervisor u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .run_stop_i(run), .real_input_device_i(pin), .hardware_emergency_stop_terminal_n_i(estop_n),
    .compute_busy_i(busy), .servo_warn_i(swarn), .warn_axis_i(wax), .warn_code_i(wcode),
    .program_no_i(tw), .time_ym_i(tw), .time_dh_i(tw), .time_ms_i(tw), .cycle_tick_o(tick),
    .servo_stop_o(stop), .controller_ready_flag_o(ready), .cycle_overrun_flag_o(ovr),
    .motion_error_flag_o(merr));

  servo_side_model u_far (.clk_i(clk_i), .rst_i(sys_rst_i), .cycle_tick_i(tick), .slow_i(slow),
    .warn_req_i(wreq), .axis_i(ax), .code_i(code), .compute_busy_o(busy), .servo_warn_o(swarn),
    .warn_axis_o(wax), .warn_code_o(wcode));

  task summarize;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One AHB-Lite single word transfer; hready is waited for with a bound.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    i = 0;
    do begin @(posedge clk_i); i++; end while (hreadyout !== 1'b1 && i < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_i); i++; end while (hreadyout !== 1'b1 && i < 100);
    #1 r = rd_smp;
    if (i >= 100) begin n_fail++; summarize(); end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, x);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, x);
    `CHK(x, e)
    `CHK(hresp, 1'b0)
  endtask

  // Bounded wait for one flag to reach a level; running out is a mismatch.
  task waitv(input int w, input logic v);
    int i;
    for (i = 0; i < 30000 && obs[w] !== v; i++) @(posedge clk_i) #1;
    `CHK(obs[w], v)
    if (i >= 30000) summarize();
  endtask

  function automatic logic [31:0] ctrl(input logic [3:0] s, input logic [1:0] os,
                                       input logic g, input logic rep, input logic r,
                                       input logic [5:0] axes);
    return {10'h0, axes, 5'h0, r, 1'b1, 1'b0, rep, g, os, s};
  endfunction
  function automatic logic [31:0] exp_us(input logic [3:0] s);
    case (s)
      4'h1: return {16'h0, `MCS_US_0P2};
      4'h2: return {16'h0, `MCS_US_0P4};
      4'h3: return {16'h0, `MCS_US_0P8};
      4'h4: return {16'h0, `MCS_US_1P7};
      4'h5: return {16'h0, `MCS_US_3P5};
      4'h6: return {16'h0, `MCS_US_7P1};
      default: return {16'h0, `MCS_US_14P2};
    endcase
  endfunction

  // Warning pulse with the given axis and code and a random program and time word.
  task warn(input logic [4:0] a, input word_t c);
    @(posedge clk_i);
    wreq <= 1'b1; ax <= a; code <= c; tw <= word_t'($urandom);
    @(posedge clk_i);
    wreq <= 1'b0;
    repeat (16) @(posedge clk_i) #1;
  endtask

  initial
  begin
    n_fail = 0; n_compared = 0; sys_rst_i = 1'b1; run = 1'b1; pin = 1'b0; estop_n = 1'b1;
    slow = 1'b0; wreq = 1'b0; ax = 5'h0; code = 16'h0; tw = 16'h0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    void'($urandom(32'h21bf));
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    waitv(0, 1'b1);
    rdchk(12'h000, `MCS_CTRL_RESET);
    `CHK(stop, 1'b1)
    wr(12'h000, 32'h0001_0380);
    waitv(3, 1'b0);
    estop_n <= 1'b0;
    waitv(3, 1'b1);
    estop_n <= 1'b1;
    wr(12'h000, ctrl(4'h0, 2'h0, 1'b0, 1'b1, 1'b0, 6'h1));
    waitv(3, 1'b1);
    pin <= 1'b1;
    waitv(3, 1'b0);
    rdchk(12'h010, exp_us(4'h1));
    wr(12'h000, ctrl(4'h0, 2'h1, 1'b0, 1'b1, 1'b0, 6'h1));
    rdchk(12'h010, exp_us(4'h2));
    wr(12'h000, ctrl(4'h0, 2'h2, 1'b0, 1'b1, 1'b0, 6'h20));
    rdchk(12'h010, exp_us(4'h5));
    for (int s = 7; s >= 1; s--)
    begin
      wr(12'h000, ctrl(4'(s), 2'h0, 1'b0, 1'b1, 1'b0, 6'h1));
      rdchk(12'h010, exp_us(4'(s)));
    end
    run <= 1'b0;
    waitv(0, 1'b0);
    run <= 1'b1;
    waitv(0, 1'b1);
    run <= 1'b0;
    waitv(0, 1'b0);
    wr(12'h000, ctrl(4'h1, 2'h0, 1'b1, 1'b1, 1'b0, 6'h1));
    run <= 1'b1;
    repeat (8) @(posedge clk_i) #1;
    `CHK(ready, 1'b0)
    wr(12'h004, 32'h1);
    waitv(0, 1'b1);
    wr(12'h004, 32'h0);
    waitv(0, 1'b0);
    wr(12'h000, ctrl(4'h1, 2'h0, 1'b1, 1'b1, 1'b1, 6'h1));
    waitv(0, 1'b1);
    run <= 1'b0;
    waitv(0, 1'b0);
    warn(5'($urandom), word_t'($urandom));
    waitv(2, 1'b1);
    rdchk(12'h100 + {5'h0, ax, 2'h0}, {16'h0, code});
    rdchk(12'h200 + {5'h0, ax, 2'h0}, {16'h0, code});
    rdchk(12'h404, {16'h0, `MCS_WARN_TYPE});
    rdchk(12'h408, {26'h0, 6'({1'b0, ax} + 6'h1)});
    rdchk(12'h40c, {16'h0, code});
    rdchk(12'h400, {16'h0, tw});
    rdchk(12'h014, {16'h0, code});
    wr(12'h008, 32'h4);
    wr(12'h000, ctrl(4'h1, 2'h0, 1'b1, 1'b0, 1'b0, 6'h1));
    x = {16'h0, code};
    warn(ax, ~code);
    `CHK(merr, 1'b0)
    rdchk(12'h014, {16'h0, ~code});
    rdchk(12'h100 + {5'h0, ax, 2'h0}, x);
    rdchk(12'h200 + {5'h0, ax, 2'h0}, {16'h0, code});
    // Tick to tick is one whole cycle; the partner's 200-clock load reads as two microseconds.
    waitv(4, 1'b1);
    t0 = $time;
    repeat (250) @(posedge clk_i);
    rdchk(12'h00c, 32'h2);
    slow <= 1'b1;
    waitv(4, 1'b1);
    `CHK($time - t0, exp_us(4'h1) * `MCS_US_NS)
    waitv(1, 1'b1);
    rdchk(12'h00c, exp_us(4'h1));
    summarize();
  end
endmodule
